// ---- common/field_monitor_pkg.sv ----
// Constants, field layout and threshold lookup for the field monitor and bias trim block.
// Assumes one clock domain and a register port owned by the serial front end.
//
// Notes on behaviour
// - The bias trim amount is an unsigned 8-bit value from 0 to 255 that sets how far an enabled axis is reduced.
// - A trim amount of zero, the reset value, leaves both axes untrimmed.
// - The X trim enable applies the trim amount to the X axis when 1 and none when 0.
// - The Y trim enable applies the trim amount to the Y axis when 1 and none when 0.
// - With both enables set, both axes get the same reduction, so no side-shaft correction results.
// - The low flag rises when the field falls below the low threshold, the high flag when it exceeds the high one.
// - Both flags switch with a hysteresis of 6 mT between rising and falling points.
// - The threshold register holds the 3-bit low threshold in bits 7:5 and the 3-bit high threshold in bits 4:2.
// - Rising points for codes 0 to 7 are 26, 41, 56, 70, 84, 98, 112 and 126 mT.
// - Falling points for codes 0 to 7 are 20, 35, 50, 64, 78, 92, 106 and 120 mT.
// - The status register shows the high flag in bit 7 and the low flag in bit 6, and both flags drive output pins.
// - A low threshold code larger than the high threshold code is accepted as is.

package field_monitor_pkg;

    localparam int unsigned ADDR_W = 5;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned MAG_W = 8;
    localparam int unsigned CODE_W = 3;

    // ****************************************
    // Register offsets
    // ****************************************
    localparam logic [4:0] ADDR_TRIM_ENABLE = 5'h02;
    localparam logic [4:0] ADDR_TRIM_AMOUNT = 5'h03;
    localparam logic [4:0] ADDR_FIELD_THRESHOLD = 5'h06;
    localparam logic [4:0] ADDR_FIELD_STATUS = 5'h1B;

    // ****************************************
    // Field positions
    // ****************************************
    localparam int unsigned EN_X_BIT = 0;
    localparam int unsigned EN_Y_BIT = 1;
    localparam int unsigned THR_LOW_LSB = 5;
    localparam int unsigned THR_HIGH_LSB = 2;
    localparam int unsigned STAT_HIGH_BIT = 7;
    localparam int unsigned STAT_LOW_BIT = 6;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [7:0] TRIM_AMOUNT_RST = 8'h00;
    localparam logic TRIM_ENABLE_RST = 1'b0;
    localparam logic [2:0] THRESHOLD_RST = 3'h0;

    // ****************************************
    // Field thresholds in mT
    // ****************************************
    localparam logic [7:0] FIELD_FLAG_HYSTERESIS_MT = 8'h06;
    localparam logic [7:0] RISE_MT [8] = '{8'h1A, 8'h29, 8'h38, 8'h46, 8'h54, 8'h62, 8'h70, 8'h7E};

    typedef enum logic {FLAG_LOW_SIDE, FLAG_HIGH_SIDE} flag_side_t;

    function automatic logic [7:0] riseMt(input logic [2:0] code);
        return RISE_MT[code];
    endfunction : riseMt

    // Falling points sit one hysteresis step below the rising ones
    function automatic logic [7:0] fallMt(input logic [2:0] code);
        return RISE_MT[code] - FIELD_FLAG_HYSTERESIS_MT;
    endfunction : fallMt

endpackage : field_monitor_pkg

// ---- verilog/axis_trim.sv ----
// One axis of the bias trim: registered trim value for that axis.
// Assumes an active-low reset from the top, asserted asynchronously and released in step with the clock.
`timescale 1ns/100ps
`default_nettype none

module axis_trim
    import field_monitor_pkg::*;
#(
    parameter int unsigned TRIM_W = 8
) (
    input wire logic clk_sys, // System clock
    input wire logic rstSyncN, // Released reset copy
    input wire logic trimEnable, // Axis trim enable
    input wire logic [TRIM_W-1:0] trimAmount, // Stored trim amount
    output logic [TRIM_W-1:0] trimOut // Reduction applied to this axis
);

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            trimOut <= '0;
        end else if (trimEnable) begin
            trimOut <= trimAmount;
        end else begin
            trimOut <= '0;
        end
    end

endmodule : axis_trim

`default_nettype wire

// ---- verilog/field_flag_hyst.sv ----
// One field flag with hysteresis, updated on each field sample.
// Assumes the magnitude is in mT, one LSB per mT, valid when the strobe is high.
`timescale 1ns/100ps
`default_nettype none

module field_flag_hyst
    import field_monitor_pkg::*;
#(
    parameter flag_side_t SIDE = FLAG_HIGH_SIDE
) (
    input wire logic clk_sys, // System clock
    input wire logic rstSyncN, // Released reset copy
    input wire logic sampleValid, // New magnitude sample
    input wire logic [MAG_W-1:0] magnitude, // Field magnitude in mT
    input wire logic [CODE_W-1:0] thresholdCode, // Threshold code
    output logic flag // Flag state
);

    logic aboveRise;
    logic belowFall;

    // Between the two points the flag keeps its state
    assign aboveRise = magnitude > riseMt(thresholdCode);
    assign belowFall = magnitude < fallMt(thresholdCode);

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            flag <= 1'b0;
        end else if (sampleValid) begin
            if (SIDE == FLAG_HIGH_SIDE) begin
                if (aboveRise) begin
                    flag <= 1'b1;
                end else if (belowFall) begin
                    flag <= 1'b0;
                end
            end else begin
                if (belowFall) begin
                    flag <= 1'b1;
                end else if (aboveRise) begin
                    flag <= 1'b0;
                end
            end
        end
    end

endmodule : field_flag_hyst

`default_nettype wire

// ---- verilog/field_monitor_trim_config.sv ----
// Top of the field monitor and bias trim configuration block.
// Assumes the serial front end turns host transfers into
// one-cycle read and write strobes on the register port,
// and that the front end samples a field magnitude in mT.
`timescale 1ns/100ps
`default_nettype none

module field_monitor_trim_config
    import field_monitor_pkg::*;
(
    input wire logic clk_sys, // System clock, 200 MHz
    input wire logic nrst, // Asynchronous reset, active low
    input wire logic regWrEn, // Register write strobe
    input wire logic regRdEn, // Register read strobe
    input wire logic [ADDR_W-1:0] regAddr, // Register index
    input wire logic [DATA_W-1:0] regWrData, // Write data
    output logic [DATA_W-1:0] regRdData, // Read data
    output logic regRdValid, // Read data valid strobe
    input wire logic fieldValid, // Field sample strobe
    input wire logic [MAG_W-1:0] fieldMagnitude, // Field magnitude in mT
    output logic fieldLowFlag, // Low field flag pin
    output logic fieldHighFlag, // High field flag pin
    output logic [DATA_W-1:0] xBiasTrim, // X axis reduction
    output logic [DATA_W-1:0] yBiasTrim // Y axis reduction
);

    // ****************************************
    // Reset release
    // ****************************************
    logic rstMeta;
    logic rstSyncN;

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rstMeta <= 1'b0;
            rstSyncN <= 1'b0;
        end else begin
            rstMeta <= 1'b1;
            rstSyncN <= rstMeta;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    logic [DATA_W-1:0] biasTrimAmount;
    logic xAxisTrimEnable;
    logic yAxisTrimEnable;
    logic [CODE_W-1:0] lowFieldThreshold;
    logic [CODE_W-1:0] highFieldThreshold;
    logic wrTrimAmount;
    logic wrTrimEnable;
    logic wrThreshold;

    assign wrTrimAmount = regWrEn && (regAddr == ADDR_TRIM_AMOUNT);
    assign wrTrimEnable = regWrEn && (regAddr == ADDR_TRIM_ENABLE);
    assign wrThreshold = regWrEn && (regAddr == ADDR_FIELD_THRESHOLD);

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            biasTrimAmount <= TRIM_AMOUNT_RST;
        end else if (wrTrimAmount) begin
            biasTrimAmount <= regWrData;
        end
    end

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            xAxisTrimEnable <= TRIM_ENABLE_RST;
            yAxisTrimEnable <= TRIM_ENABLE_RST;
        end else if (wrTrimEnable) begin
            // Any combination is legal; picking one axis is up to the host
            xAxisTrimEnable <= regWrData[EN_X_BIT];
            yAxisTrimEnable <= regWrData[EN_Y_BIT];
        end
    end

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            lowFieldThreshold <= THRESHOLD_RST;
            highFieldThreshold <= THRESHOLD_RST;
        end else if (wrThreshold) begin
            // No ordering check between the two codes
            lowFieldThreshold <= regWrData[THR_LOW_LSB +: CODE_W];
            highFieldThreshold <= regWrData[THR_HIGH_LSB +: CODE_W];
        end
    end

    // ****************************************
    // Read path
    // ****************************************
    logic [DATA_W-1:0] next_regRdData;

    always_comb begin
        next_regRdData = '0;
        case (regAddr)
            ADDR_TRIM_AMOUNT: begin
                next_regRdData = biasTrimAmount;
            end
            ADDR_TRIM_ENABLE: begin
                next_regRdData[EN_X_BIT] = xAxisTrimEnable;
                next_regRdData[EN_Y_BIT] = yAxisTrimEnable;
            end
            ADDR_FIELD_THRESHOLD: begin
                next_regRdData[THR_LOW_LSB +: CODE_W] = lowFieldThreshold;
                next_regRdData[THR_HIGH_LSB +: CODE_W] = highFieldThreshold;
            end
            ADDR_FIELD_STATUS: begin
                next_regRdData[STAT_HIGH_BIT] = fieldHighFlag;
                next_regRdData[STAT_LOW_BIT] = fieldLowFlag;
            end
            default: begin
                next_regRdData = '0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstSyncN) begin
        if (!rstSyncN) begin
            regRdData <= '0;
            regRdValid <= 1'b0;
        end else begin
            regRdValid <= regRdEn;
            if (regRdEn) begin
                regRdData <= next_regRdData;
            end
        end
    end

    // ****************************************
    // Axis trim
    // ****************************************
    axis_trim #(
        .TRIM_W(DATA_W)
    ) u_trim_x (
        .clk_sys(clk_sys),
        .rstSyncN(rstSyncN),
        .trimEnable(xAxisTrimEnable),
        .trimAmount(biasTrimAmount),
        .trimOut(xBiasTrim)
    );

    // Same amount feeds both axes, so both-enabled trims equally
    axis_trim #(
        .TRIM_W(DATA_W)
    ) u_trim_y (
        .clk_sys(clk_sys),
        .rstSyncN(rstSyncN),
        .trimEnable(yAxisTrimEnable),
        .trimAmount(biasTrimAmount),
        .trimOut(yBiasTrim)
    );

    // ****************************************
    // Field flags
    // ****************************************
    field_flag_hyst #(
        .SIDE(FLAG_LOW_SIDE)
    ) u_flag_low (
        .clk_sys(clk_sys),
        .rstSyncN(rstSyncN),
        .sampleValid(fieldValid),
        .magnitude(fieldMagnitude),
        .thresholdCode(lowFieldThreshold),
        .flag(fieldLowFlag)
    );

    field_flag_hyst #(
        .SIDE(FLAG_HIGH_SIDE)
    ) u_flag_high (
        .clk_sys(clk_sys),
        .rstSyncN(rstSyncN),
        .sampleValid(fieldValid),
        .magnitude(fieldMagnitude),
        .thresholdCode(highFieldThreshold),
        .flag(fieldHighFlag)
    );

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk_sys);
    endclocking

    default disable iff (!rstSyncN);

    logic [7:0] hiRise;
    logic [7:0] hiFall;
    logic [7:0] loRise;
    logic [7:0] loFall;

    assign hiRise = riseMt(highFieldThreshold);
    assign hiFall = fallMt(highFieldThreshold);
    assign loRise = riseMt(lowFieldThreshold);
    assign loFall = fallMt(lowFieldThreshold);

    a_trim_x_value: assert property (
        ##1 xBiasTrim == ($past(xAxisTrimEnable) ? $past(biasTrimAmount) : 8'h00)
    ) else $error("X trim does not follow enable and amount");

    a_trim_y_value: assert property (
        ##1 yBiasTrim == ($past(yAxisTrimEnable) ? $past(biasTrimAmount) : 8'h00)
    ) else $error("Y trim does not follow enable and amount");

    a_trim_both_equal: assert property (
        (xAxisTrimEnable && yAxisTrimEnable) [*2] |-> xBiasTrim == yBiasTrim
    ) else $error("Both axes enabled but trims differ");

    a_trim_zero_amount: assert property (
        (biasTrimAmount == 8'h00) [*2] |-> (xBiasTrim == 8'h00) && (yBiasTrim == 8'h00)
    ) else $error("Zero trim amount still trims an axis");

    a_amount_store: assert property (
        wrTrimAmount |=> biasTrimAmount == $past(regWrData)
    ) else $error("Trim amount write not stored");

    a_enable_store: assert property (
        wrTrimEnable
        |=> (xAxisTrimEnable == $past(regWrData[EN_X_BIT])) && (yAxisTrimEnable == $past(regWrData[EN_Y_BIT]))
    ) else $error("Trim enable write not stored");

    a_trim_write_path: assert property (
        wrTrimAmount && !regRdEn ##1 (xAxisTrimEnable && !wrTrimAmount)
        |=> xBiasTrim == $past(regWrData, 2)
    ) else $error("Written trim amount not applied to X axis");

    a_high_set: assert property (
        fieldValid && (fieldMagnitude > hiRise) |=> fieldHighFlag
    ) else $error("High flag not set above rising point");

    a_high_clear: assert property (
        fieldValid && (fieldMagnitude < hiFall) |=> !fieldHighFlag
    ) else $error("High flag not cleared below falling point");

    a_low_set: assert property (
        fieldValid && (fieldMagnitude < loFall) |=> fieldLowFlag
    ) else $error("Low flag not set below falling point");

    a_low_clear: assert property (
        fieldValid && (fieldMagnitude > loRise) |=> !fieldLowFlag
    ) else $error("Low flag not cleared above rising point");

    a_band_hold: assert property (
        fieldValid && (fieldMagnitude >= hiFall) && (fieldMagnitude <= hiRise)
        |=> $stable(fieldHighFlag)
    ) else $error("High flag moved inside hysteresis band");

    a_flag_idle: assert property (
        !fieldValid |=> $stable(fieldLowFlag) && $stable(fieldHighFlag)
    ) else $error("Flag changed without a field sample");

    a_rise_table: assert property (
        (riseMt(3'h0) == 8'h1A) && (riseMt(3'h5) == 8'h62) && (riseMt(3'h7) == 8'h7E)
    ) else $error("Rising threshold table wrong");

    a_fall_table: assert property (
        (fallMt(3'h0) == 8'h14) && (fallMt(3'h1) == 8'h23) && (fallMt(3'h7) == 8'h78)
    ) else $error("Falling threshold table wrong");

    a_status_read: assert property (
        regRdEn && (regAddr == ADDR_FIELD_STATUS)
        |=> regRdValid && (regRdData == {$past(fieldHighFlag), $past(fieldLowFlag), 6'h00})
    ) else $error("Status read does not show the flags");

    // Host reads at the earliest one idle cycle after its write
    a_thr_readback: assert property (
        wrThreshold ##1 !wrThreshold ##1 (regRdEn && !regWrEn && (regAddr == ADDR_FIELD_THRESHOLD))
        |=> regRdData == ($past(regWrData, 3) & 8'hFC)
    ) else $error("Threshold register readback wrong");

    a_thr_unordered: assert property (
        wrThreshold && (regWrData[7:5] > regWrData[4:2])
        |=> (lowFieldThreshold == $past(regWrData[7:5]))
            && (highFieldThreshold == $past(regWrData[4:2]))
    ) else $error("Low code above high code was not stored");

    a_thr_immediate: assert property (
        wrThreshold ##1 (fieldValid && (fieldMagnitude > riseMt($past(regWrData[4:2]))))
        |=> fieldHighFlag
    ) else $error("New high threshold not used right after write");

    a_unmapped_zero: assert property (
        regRdEn && (regAddr == 5'h1F) |=> regRdData == 8'h00
    ) else $error("Unmapped register reads non-zero");

    a_rd_valid_once: assert property (
        !regRdEn |=> !regRdValid
    ) else $error("Read valid without a read strobe");

    c_high_flag_set: cover property (
        !fieldHighFlag ##1 fieldHighFlag
    );

    c_low_flag_set: cover property (
        !fieldLowFlag ##1 fieldLowFlag
    );

    c_x_only_trim: cover property (
        xAxisTrimEnable && !yAxisTrimEnable && (xBiasTrim != 8'h00)
    );

    c_low_above_high: cover property (
        (lowFieldThreshold > highFieldThreshold) && fieldLowFlag && fieldHighFlag
    );

endmodule : field_monitor_trim_config

`default_nettype wire

// ---- dv/host_model.sv ----
// Host controller model on the register port of the field monitor block.
// Assumes tasks are entered just after a rising edge of clk_sys.
`timescale 1ns/100ps
`default_nettype none

module host_model
    import field_monitor_pkg::*;
(
    input wire logic clk_sys, // System clock
    output logic regWrEn, // Write strobe
    output logic regRdEn, // Read strobe
    output logic [ADDR_W-1:0] regAddr, // Register index
    output logic [DATA_W-1:0] regWrData, // Write data
    input wire logic [DATA_W-1:0] regRdData, // Read data
    input wire logic regRdValid // Read data valid
);
    // ****************************************
    // Register transfers
    // ****************************************
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = '0;
        regWrData = '0;
    end

    // Idle lines show the inverse so a stale value cannot pass for a fresh one
    task automatic regWrite(input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
        @(posedge clk_sys);
        #1;
        regWrEn = 1'b1;
        regAddr = addr;
        regWrData = data;
        @(posedge clk_sys);
        #1;
        regWrEn = 1'b0;
        regAddr = ~addr;
        regWrData = ~data;
    endtask : regWrite

    task automatic regRead(input logic [ADDR_W-1:0] addr, output logic [DATA_W-1:0] data, output logic valid);
        @(posedge clk_sys);
        #1;
        regRdEn = 1'b1;
        regAddr = addr;
        @(posedge clk_sys);
        #1;
        regRdEn = 1'b0;
        regAddr = ~addr;
        valid = regRdValid;
        data = regRdData;
    endtask : regRead

    // Side-shaft setup trims only the axis with the stronger radial field
    task automatic trimOneAxis(input logic xAxis, input logic [DATA_W-1:0] amount);
        regWrite(ADDR_TRIM_ENABLE, {6'h00, ~xAxis, xAxis});
        regWrite(ADDR_TRIM_AMOUNT, amount);
    endtask : trimOneAxis

endmodule : host_model

`default_nettype wire

// ---- dv/field_monitor_trim_config_test.sv ----
// Self-checking testbench of the field monitor and trim configuration block.
// Assumes the host model owns the register port; field samples come from here.
`timescale 1ns/100ps
`default_nettype none

module field_monitor_trim_config_test
    import field_monitor_pkg::*;
;
    logic clk_sys, nrst, regWrEn, regRdEn, regRdValid, fieldValid, fieldLowFlag, fieldHighFlag;
    logic [ADDR_W-1:0] regAddr;
    logic [DATA_W-1:0] regWrData, regRdData, xBiasTrim, yBiasTrim;
    logic [MAG_W-1:0] fieldMagnitude;
    int n_fail = 0;
    int samples_checked = 0;
    localparam int RISE [8] = '{26, 41, 56, 70, 84, 98, 112, 126};
    localparam int FALL [8] = '{20, 35, 50, 64, 78, 92, 106, 120};

    field_monitor_trim_config i_field_monitor_trim_config (.clk_sys(clk_sys), .nrst(nrst),
        .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
        .regRdData(regRdData), .regRdValid(regRdValid), .fieldValid(fieldValid),
        .fieldMagnitude(fieldMagnitude), .fieldLowFlag(fieldLowFlag), .fieldHighFlag(fieldHighFlag),
        .xBiasTrim(xBiasTrim), .yBiasTrim(yBiasTrim));

    host_model i_host_model (.clk_sys(clk_sys), .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr),
        .regWrData(regWrData), .regRdData(regRdData), .regRdValid(regRdValid));

    initial clk_sys = 1'b0;
    always #2.5 clk_sys = ~clk_sys;

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic rdChk(input logic [ADDR_W-1:0] addr, input logic [7:0] exp);
        logic [7:0] d;
        logic v;
        i_host_model.regRead(addr, d, v);
        chk({7'h00, v}, 8'h01);
        chk(d, exp);
    endtask : rdChk

    // Flags are registered: look one edge after the sample edge
    task automatic flagStep(input int mag, input logic h, input logic l);
        fieldValid = 1'b1;
        fieldMagnitude = 8'(mag);
        @(posedge clk_sys);
        #1;
        fieldValid = 1'b0;
        fieldMagnitude = ~fieldMagnitude;
        @(posedge clk_sys);
        #1;
        chk({7'h00, fieldHighFlag}, {7'h00, h});
        chk({7'h00, fieldLowFlag}, {7'h00, l});
        rdChk(ADDR_FIELD_STATUS, {h, l, 6'h00});
    endtask : flagStep

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_resetValues();
        rdChk(ADDR_TRIM_ENABLE, 8'h00);
        rdChk(ADDR_TRIM_AMOUNT, 8'h00);
        rdChk(ADDR_FIELD_THRESHOLD, 8'h00);
        rdChk(ADDR_FIELD_STATUS, 8'h00);
        chk(xBiasTrim, 8'h00);
        chk(yBiasTrim, 8'h00);
    endtask : t_resetValues

    task automatic t_trim();
        logic [7:0] amt [3] = '{8'h00, 8'hFF, 8'h5A};
        for (int a = 0; a < 3; a++) begin
            for (int en = 0; en < 4; en++) begin
                i_host_model.regWrite(ADDR_TRIM_AMOUNT, amt[a]);
                i_host_model.regWrite(ADDR_TRIM_ENABLE, {6'h3F, 2'(en)});
                @(posedge clk_sys);
                #1;
                chk(xBiasTrim, en[0] ? amt[a] : 8'h00);
                chk(yBiasTrim, en[1] ? amt[a] : 8'h00);
                rdChk(ADDR_TRIM_ENABLE, {6'h00, 2'(en)});
                rdChk(ADDR_TRIM_AMOUNT, amt[a]);
            end
        end
        i_host_model.trimOneAxis(1'b1, 8'h81);
        @(posedge clk_sys);
        #1;
        chk(xBiasTrim, 8'h81);
        chk(yBiasTrim, 8'h00);
    endtask : t_trim

    task automatic t_thresholds();
        logic [2:0] code;
        for (int c = 0; c < 8; c++) begin
            code = 3'(c);
            i_host_model.regWrite(ADDR_FIELD_THRESHOLD, {code, code, 2'b11});
            rdChk(ADDR_FIELD_THRESHOLD, {code, code, 2'b00});
            flagStep(RISE[c] + 1, 1'b1, 1'b0);
            flagStep(FALL[c], 1'b1, 1'b0);
            flagStep(FALL[c] - 1, 1'b0, 1'b1);
            flagStep(RISE[c], 1'b0, 1'b1);
            flagStep(RISE[c] + 1, 1'b1, 1'b0);
        end
    endtask : t_thresholds

    // Threshold write is followed by a sample at the very next edge
    task automatic t_orderAndUpdate();
        i_host_model.regWrite(ADDR_FIELD_THRESHOLD, 8'hE0);
        flagStep(100, 1'b1, 1'b1);
        i_host_model.regWrite(ADDR_FIELD_THRESHOLD, 8'h1C);
        flagStep(119, 1'b0, 1'b0);
    endtask : t_orderAndUpdate

    task automatic t_refusals();
        i_host_model.regWrite(ADDR_FIELD_STATUS, 8'hFF);
        rdChk(ADDR_FIELD_STATUS, 8'h00);
        i_host_model.regWrite(5'h10, 8'hFF);
        rdChk(5'h10, 8'h00);
        rdChk(5'h1F, 8'h00);
    endtask : t_refusals

    task automatic stop_test();
        if (n_fail == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        stop_test();
    end

    initial begin
        nrst = 1'b0;
        fieldValid = 1'b0;
        fieldMagnitude = '0;
        repeat (20) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        repeat (3) @(posedge clk_sys);
        #1;
        t_resetValues();
        t_trim();
        t_thresholds();
        t_orderAndUpdate();
        t_refusals();
        stop_test();
    end

endmodule : field_monitor_trim_config_test

`default_nettype wire
